// [hdl/halfbridge_deadtime_cap_guard.sv]
// Gate sequencing with adaptive dead time and capacitive-mode guard
// Functional notes
// - Ramp at upper threshold sets oscillator flip-flop, discharge at double rate.
// - Ramp below lower threshold resets flip-flop, stops discharge, new cycle.
// - Each start or restart begins at high frequency, decaying to loop control.
// - After high-side off, low-side waits for slew end plus minimum delay.
// - After low-side off, high-side likewise waits for slew end plus minimum delay.
// - No gate turns on sooner than 235 ns after the opposite turns off.
// - Without slew end, force the pending gate on at 1 us dead time.
// - With no slew indication, dead time is fixed at 350 ns.
// - Low negative flag at low-side off blocks high-side turn-on.
// - High positive flag at high-side off lets normal dead time proceed.
// - During capacitive block, dead window flag stays high and ramp halts.
// - After polarity recovers, opposite gate waits for slew detection.
// - Capacitive-mode timeout forces the opposite gate on.
// - Capacitive mode raises soft-start discharge control, acting after 1 us blanking.
// - First gate turning off after the event clears control, restarts soft start.
// - Low positive flag at high-side off blocks low-side until slew or timeout.
// - Discharge after blanking only while the capacitive fault remains.
`timescale 1ns/1ps
module halfbridge_deadtime_cap_guard #(
    parameter int CAP_TIMEOUT_CYC = hb_guard_pkg::CAP_TO_CYC
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [hb_guard_pkg::STEP_W-1:0] freq_set_input,
    input wire logic slew_sense_input,
    input wire logic polarity_pos_flag,
    input wire logic polarity_neg_flag,
    output logic high_gate_drive,
    output logic low_gate_drive,
    output logic dead_window_flag,
    output logic ss_control_flag,
    output logic ss_discharge,
    output logic [hb_guard_pkg::RAMP_W-1:0] timing_ramp
);
    import hb_guard_pkg::*;

    // Three-stage synchronisers with agreement filter
    logic [2:0] s1_r, s2_r, s3_r, filt_r;
    logic [2:0] filt_nxt;

    always_comb begin
        filt_nxt = filt_r;
        for (int i = 0; i < 3; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                filt_nxt[i] = s2_r[i];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s1_r <= SYNC_RST;
            s2_r <= SYNC_RST;
            s3_r <= SYNC_RST;
            filt_r <= SYNC_RST;
        end else begin
            s1_r <= {polarity_neg_flag, polarity_pos_flag, slew_sense_input};
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= filt_nxt;
        end
    end

    wire logic slewing = filt_r[SYNC_SLEW];
    wire logic pos_ok = filt_r[SYNC_POS];
    wire logic neg_ok = filt_r[SYNC_NEG];

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        return (&v) ? v : v + 12'h001;
    endfunction

    bridge_state_e state_r, state_nxt;
    logic [RAMP_W-1:0] ramp_r, ramp_nxt;
    logic osc_r, osc_nxt;
    logic [STEP_W-1:0] boost_r, boost_nxt;
    logic [CNT_W-1:0] ss_div_r, ss_div_nxt;
    logic [CNT_W-1:0] dt_cnt_r, dt_cnt_nxt;
    logic [CNT_W-1:0] end_cnt_r, end_cnt_nxt;
    logic [CNT_W-1:0] blank_cnt_r, blank_cnt_nxt;
    logic slew_seen_r, slew_seen_nxt;
    logic slew_end_r, slew_end_nxt;
    logic sense_ok_r, sense_ok_nxt;
    logic block_r, block_nxt;
    logic ss_ctrl_r, ss_ctrl_nxt;
    logic ss_dis_r, ss_dis_nxt;
    logic cap_arm_r, cap_arm_nxt;
    logic hg_r, hg_nxt;
    logic lg_r, lg_nxt;
    logic dw_r, dw_nxt;

    logic [RAMP_W:0] up_sum, dn_step;
    logic [STEP_W:0] step;
    logic gate_off, gate_on, pol_good, fault_now;

    always_comb begin
        state_nxt = state_r;
        ramp_nxt = ramp_r;
        osc_nxt = osc_r;
        boost_nxt = boost_r;
        ss_div_nxt = ss_div_r;
        dt_cnt_nxt = dt_cnt_r;
        end_cnt_nxt = end_cnt_r;
        blank_cnt_nxt = blank_cnt_r;
        slew_seen_nxt = slew_seen_r;
        slew_end_nxt = slew_end_r;
        sense_ok_nxt = sense_ok_r;
        block_nxt = block_r;
        ss_ctrl_nxt = ss_ctrl_r;
        cap_arm_nxt = cap_arm_r;
        gate_off = 1'b0;
        gate_on = 1'b0;
        // Soft-start boost raises the charge current, hence frequency
        step = {1'b0, freq_set_input} + {1'b0, boost_r};
        if (step == 9'h000) begin
            step = 9'h001;
        end
        up_sum = {1'b0, ramp_r} + {8'h00, step};
        // Discharge sink is twice the charge source, so the net fall slope equals the rise
        dn_step = {8'h00, step};
        fault_now = 1'b0;

        // Oscillator, frozen while capacitive mode blocks switching
        if (!block_r) begin
            if (!osc_r) begin
                if (up_sum >= {1'b0, RAMP_TOP}) begin
                    ramp_nxt = RAMP_TOP;
                    osc_nxt = 1'b1;
                end else begin
                    ramp_nxt = up_sum[RAMP_W-1:0];
                end
            end else begin
                // Double-rate discharge keeps both halves equal
                if ({1'b0, ramp_r} <= ({1'b0, RAMP_BOT} + dn_step)) begin
                    ramp_nxt = RAMP_BOT;
                    osc_nxt = 1'b0;
                end else begin
                    ramp_nxt = ramp_r - dn_step[RAMP_W-1:0];
                end
            end
        end

        // Exponential-like decay of the start-up boost
        if (ss_ctrl_r) begin
            boost_nxt = SS_BOOST_MAX;
            ss_div_nxt = '0;
        end else if (ss_div_r == CNT_W'(SS_STEP_CYC - 1)) begin
            ss_div_nxt = '0;
            if (boost_r != '0) begin
                boost_nxt = boost_r - (boost_r >> SS_SHIFT) - 8'h01;
            end
        end else begin
            ss_div_nxt = ss_div_r + 12'h001;
        end

        pol_good = (state_r == ST_DEAD_LH) ? neg_ok : pos_ok;

        case (state_r)
            ST_HIGH: begin
                if (osc_r) begin
                    gate_off = 1'b1;
                    state_nxt = ST_DEAD_HL;
                    // Low positive flag here means the current already reversed
                    block_nxt = !pos_ok;
                end
            end
            ST_LOW: begin
                if (!osc_r) begin
                    gate_off = 1'b1;
                    state_nxt = ST_DEAD_LH;
                    block_nxt = !neg_ok;
                end
            end
            ST_DEAD_HL, ST_DEAD_LH: begin
                dt_cnt_nxt = sat_inc(dt_cnt_r);
                // Slew seen under wrong polarity is not a real transition
                if (slewing && (!block_r || pol_good)) begin
                    slew_seen_nxt = 1'b1;
                    slew_end_nxt = 1'b0;
                    end_cnt_nxt = '0;
                end else if (slew_seen_r && !slewing) begin
                    slew_end_nxt = 1'b1;
                    end_cnt_nxt = sat_inc(end_cnt_r);
                end
                if (block_r) begin
                    if (dt_cnt_r >= CNT_W'(CAP_TIMEOUT_CYC - 1)) begin
                        gate_on = 1'b1;
                    end else if (pol_good && slew_end_r && end_cnt_r >= CNT_W'(DT_MIN_CYC - 1)
                                 && dt_cnt_r >= CNT_W'(DT_MIN_CYC - 1)) begin
                        gate_on = 1'b1;
                    end
                end else if (dt_cnt_r >= CNT_W'(DT_MIN_CYC - 1)) begin
                    if (slew_end_r && end_cnt_r >= CNT_W'(DT_MIN_CYC - 1)) begin
                        gate_on = 1'b1;
                    end else if (dt_cnt_r >= CNT_W'(DT_MAX_CYC - 1)) begin
                        gate_on = 1'b1;
                    end else if (!sense_ok_r && !slew_seen_r
                                 && dt_cnt_r >= CNT_W'(DT_FIX_CYC - 1)) begin
                        gate_on = 1'b1;
                    end
                end
                if (gate_on) begin
                    state_nxt = (state_r == ST_DEAD_HL) ? ST_LOW : ST_HIGH;
                    // A window with no slew at all marks the sense pin as absent
                    sense_ok_nxt = slew_seen_r || slewing;
                    block_nxt = 1'b0;
                    dt_cnt_nxt = '0;
                    end_cnt_nxt = '0;
                    slew_seen_nxt = 1'b0;
                    slew_end_nxt = 1'b0;
                    if (block_r) begin
                        cap_arm_nxt = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = ST_HIGH;
            end
        endcase

        // Soft-start discharge control
        if (gate_off && !block_nxt && cap_arm_r) begin
            ss_ctrl_nxt = 1'b0;
            cap_arm_nxt = 1'b0;
        end
        if (gate_off && block_nxt) begin
            ss_ctrl_nxt = 1'b1;
            cap_arm_nxt = 1'b0;
            blank_cnt_nxt = '0;
        end else if (ss_ctrl_r) begin
            blank_cnt_nxt = sat_inc(blank_cnt_r);
        end
        // Blanking filters out sense noise before the node is pulled down
        // Fault judged on the next state so discharge ends with the block
        fault_now = block_nxt;
        ss_dis_nxt = 1'b0;
        if (ss_ctrl_nxt && !(gate_off && block_nxt) && fault_now) begin
            if (blank_cnt_r >= CNT_W'(BLANK_CYC - 1)) begin
                ss_dis_nxt = 1'b1;
            end
        end

        hg_nxt = (state_nxt == ST_HIGH);
        lg_nxt = (state_nxt == ST_LOW);
        dw_nxt = (state_nxt == ST_DEAD_HL) || (state_nxt == ST_DEAD_LH);
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_HIGH;
            ramp_r <= RAMP_BOT;
            osc_r <= 1'b0;
            boost_r <= SS_BOOST_MAX;
            ss_div_r <= '0;
            dt_cnt_r <= '0;
            end_cnt_r <= '0;
            blank_cnt_r <= '0;
            slew_seen_r <= 1'b0;
            slew_end_r <= 1'b0;
            sense_ok_r <= 1'b0;
            block_r <= 1'b0;
            ss_ctrl_r <= 1'b0;
            ss_dis_r <= 1'b0;
            cap_arm_r <= 1'b0;
            hg_r <= 1'b0;
            lg_r <= 1'b0;
            dw_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ramp_r <= ramp_nxt;
            osc_r <= osc_nxt;
            boost_r <= boost_nxt;
            ss_div_r <= ss_div_nxt;
            dt_cnt_r <= dt_cnt_nxt;
            end_cnt_r <= end_cnt_nxt;
            blank_cnt_r <= blank_cnt_nxt;
            slew_seen_r <= slew_seen_nxt;
            slew_end_r <= slew_end_nxt;
            sense_ok_r <= sense_ok_nxt;
            block_r <= block_nxt;
            ss_ctrl_r <= ss_ctrl_nxt;
            ss_dis_r <= ss_dis_nxt;
            cap_arm_r <= cap_arm_nxt;
            hg_r <= hg_nxt;
            lg_r <= lg_nxt;
            dw_r <= dw_nxt;
        end
    end

    assign high_gate_drive = hg_r;
    assign low_gate_drive = lg_r;
    assign dead_window_flag = dw_r;
    assign ss_control_flag = ss_ctrl_r;
    assign ss_discharge = ss_dis_r;
    assign timing_ramp = ramp_r;
endmodule

// [hdl/hb_guard_pkg.sv]
// Constants and types for the half-bridge dead-time and capacitive-mode guard
package hb_guard_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // Dead-time and blanking figures in nanoseconds
    localparam int DT_MIN_NS = 235;
    localparam int DT_MAX_NS = 1000;
    localparam int DT_FIX_NS = 350;
    localparam int BLANK_NS = 1000;
    localparam int CAP_TO_NS = 50000;
    // Least times round up, longest times round down
    localparam int DT_MIN_CYC = (DT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DT_MAX_CYC = DT_MAX_NS / CLK_PERIOD_NS;
    localparam int DT_FIX_CYC = (DT_FIX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_CYC = BLANK_NS / CLK_PERIOD_NS;
    localparam int CAP_TO_CYC = CAP_TO_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    // Timing ramp
    localparam int RAMP_W = 16;
    localparam logic [RAMP_W-1:0] RAMP_TOP = 16'hc000;
    localparam logic [RAMP_W-1:0] RAMP_BOT = 16'h4000;
    localparam int STEP_W = 8;
    // Soft-start frequency boost
    localparam logic [STEP_W-1:0] SS_BOOST_MAX = 8'hff;
    localparam int SS_SHIFT = 3;
    localparam int SS_STEP_CYC = 64;
    // Synchroniser bit positions
    localparam int SYNC_SLEW = 0;
    localparam int SYNC_POS = 1;
    localparam int SYNC_NEG = 2;
    localparam logic [2:0] SYNC_RST = 3'h0;

    typedef enum {
        ST_HIGH,
        ST_DEAD_HL,
        ST_LOW,
        ST_DEAD_LH
    } bridge_state_e;
endpackage

// [testbench/hb_guard_props.sv]
// Concurrent checks on the gate guard ports
`timescale 1ns/1ps
module hb_guard_props #(
    parameter int CAP_TIMEOUT_CYC = hb_guard_pkg::CAP_TO_CYC
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic high_gate_drive,
    input wire logic low_gate_drive,
    input wire logic dead_window_flag,
    input wire logic ss_control_flag,
    input wire logic ss_discharge,
    input wire logic [hb_guard_pkg::RAMP_W-1:0] timing_ramp
);
    import hb_guard_pkg::*;
    // Order window assumes a short timeout
    localparam int LIM = 300;
    logic [11:0] off_r;
    logic [11:0] off_nxt;
    always_comb begin
        off_nxt = (off_r == 12'hfff) ? off_r : off_r + 12'h001;
        if (high_gate_drive || low_gate_drive) begin
            off_nxt = 12'h000;
        end
    end
    // Saturated at reset so the first turn-on is not flagged
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            off_r <= 12'hfff;
        end else begin
            off_r <= off_nxt;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_high_off; $fell(high_gate_drive); endsequence
    sequence s_low_on; ##[1:LIM] $rose(low_gate_drive); endsequence
    property p_excl; !(high_gate_drive && low_gate_drive); endproperty
    property p_flag; (high_gate_drive || low_gate_drive) |-> !dead_window_flag; endproperty
    // Counter holds the dead window length, in cycles, when the next gate rises
    property p_min; ($rose(high_gate_drive) || $rose(low_gate_drive)) |-> off_r >= DT_MIN_CYC - 1; endproperty
    property p_max; (dead_window_flag && !ss_control_flag) |-> off_r <= DT_MAX_CYC + 1; endproperty
    property p_cap; dead_window_flag |-> off_r <= CAP_TIMEOUT_CYC + 1; endproperty
    property p_blank; $rose(ss_discharge) |-> off_r >= BLANK_CYC - 1; endproperty
    property p_disc; ss_discharge |-> ss_control_flag; endproperty
    property p_halt; ss_discharge |-> $stable(timing_ramp); endproperty
    property p_order; s_high_off |-> (!high_gate_drive throughout s_low_on); endproperty
    property p_clear; $fell(ss_control_flag) |-> $rose(dead_window_flag); endproperty
    a_excl: assert property (p_excl) else $error("both gates on");
    a_flag: assert property (p_flag) else $error("dead flag with gate on");
    a_min: assert property (p_min) else $error("dead time too short");
    a_max: assert property (p_max) else $error("dead time too long");
    a_cap: assert property (p_cap) else $error("block outlived timeout");
    a_blank: assert property (p_blank) else $error("discharge before blanking");
    a_disc: assert property (p_disc) else $error("discharge without control");
    a_halt: assert property (p_halt) else $error("ramp moved while blocked");
    a_order: assert property (p_order) else $error("gate order broken");
    a_clear: assert property (p_clear) else $error("control cleared off gate-off");
endmodule

// [testbench/bridge_stage_model.sv]
// Power stage model: midpoint slew pulse and current polarity
`timescale 1ns/1ps
module bridge_stage_model (
    input wire logic ref_clk,
    input wire logic high_gate_drive,
    input wire logic low_gate_drive,
    input wire logic [7:0] slew_len,
    input wire logic cap_fault,
    output logic slew_sense_input,
    output logic polarity_pos_flag,
    output logic polarity_neg_flag
);
    logic last_h = 1'b0;
    logic last_l = 1'b0;
    logic pend = 1'b0;
    int cnt = 0;
    initial slew_sense_input = 1'b0;
    // Wrong polarity holds the midpoint still until the current turns
    always @(negedge ref_clk) begin
        if ((last_h && !high_gate_drive) || (last_l && !low_gate_drive)) begin
            pend = cap_fault;
            cnt = cap_fault ? 0 : int'(slew_len);
        end else if (pend && !cap_fault) begin
            pend = 1'b0;
            cnt = int'(slew_len);
        end else if (cnt > 0) begin
            cnt = cnt - 1;
        end
        last_h = high_gate_drive;
        last_l = low_gate_drive;
        slew_sense_input = (cnt > 0);
        polarity_pos_flag = !cap_fault;
        polarity_neg_flag = !cap_fault;
    end
endmodule

// [testbench/test_halfbridge_deadtime_cap_guard.sv]
// Self-checking bench for the half-bridge gate guard
`timescale 1ns/1ps
module test_halfbridge_deadtime_cap_guard;
    import hb_guard_pkg::*;
    localparam int CAP_T = 100;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [STEP_W-1:0] freq_set_input = 8'h80;
    logic [7:0] slew_len = 8'h00;
    logic cap_fault = 1'b0;
    logic slew_sense_input;
    logic polarity_pos_flag;
    logic polarity_neg_flag;
    logic high_gate_drive;
    logic low_gate_drive;
    logic dead_window_flag;
    logic ss_control_flag;
    logic ss_discharge;
    logic [RAMP_W-1:0] timing_ramp;
    int num_errors = 0;
    int n_checks = 0;
    int lo_q[$];
    int hi_q[$];
    int dead_len = 0;
    logic armed = 1'b0;
    logic saw_disc = 1'b0;
    realtime t0 = 0.0;
    realtime t1 = 0.0;
    int early = 0;
    always #10 ref_clk = ~ref_clk;
    halfbridge_deadtime_cap_guard #(.CAP_TIMEOUT_CYC(CAP_T)) halfbridge_deadtime_cap_guard_inst (
        .ref_clk(ref_clk), .reset(reset), .freq_set_input(freq_set_input),
        .slew_sense_input(slew_sense_input), .polarity_pos_flag(polarity_pos_flag),
        .polarity_neg_flag(polarity_neg_flag), .high_gate_drive(high_gate_drive),
        .low_gate_drive(low_gate_drive), .dead_window_flag(dead_window_flag),
        .ss_control_flag(ss_control_flag), .ss_discharge(ss_discharge), .timing_ramp(timing_ramp));
    bridge_stage_model bridge_stage_model_inst (
        .ref_clk(ref_clk), .high_gate_drive(high_gate_drive), .low_gate_drive(low_gate_drive),
        .slew_len(slew_len), .cap_fault(cap_fault), .slew_sense_input(slew_sense_input),
        .polarity_pos_flag(polarity_pos_flag), .polarity_neg_flag(polarity_neg_flag));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Only windows that open after a note are judged
    always @(negedge ref_clk) begin
        if (dead_window_flag === 1'b1) begin
            if (dead_len == 0) armed = (lo_q.size() > 0);
            dead_len++;
            if (ss_discharge === 1'b1) saw_disc = 1'b1;
        end else begin
            if (armed) begin
                check(16'((dead_len >= lo_q[0] && dead_len <= hi_q[0]) ? lo_q[0] : dead_len), 16'(lo_q[0]));
                void'(lo_q.pop_front());
                void'(hi_q.pop_front());
            end
            armed = 1'b0;
            dead_len = 0;
        end
    end
    task automatic note(input int lo, input int hi);
        lo_q.push_back(lo);
        hi_q.push_back(hi);
    endtask
    task automatic settle();
        for (int i = 0; i < 4000 && lo_q.size() > 0; i++) @(negedge ref_clk);
    endtask
    task automatic next_win();
        @(posedge dead_window_flag);
        @(negedge dead_window_flag);
        @(negedge ref_clk);
    endtask
    initial begin
        void'($urandom(63));
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        freq_set_input = 8'h60 + 8'($urandom % 64);
        next_win();
        repeat (2) note(DT_FIX_CYC, DT_FIX_CYC + 1);
        settle();
        $display("test fixed dead time done");
        for (int s = 8; s <= 24; s += 16) begin
            slew_len = 8'(s);
            freq_set_input = 8'h60 + 8'($urandom % 64);
            next_win();
            repeat (2) note(s + DT_MIN_CYC, s + DT_MIN_CYC + 8);
            settle();
        end
        $display("test adaptive dead time done");
        slew_len = 8'd120;
        next_win();
        repeat (2) note(DT_MAX_CYC, DT_MAX_CYC + 1);
        settle();
        $display("test forced turn-on done");
        slew_len = 8'd8;
        cap_fault = 1'b1;
        saw_disc = 1'b0;
        note(CAP_T - 1, CAP_T + 1);
        @(posedge dead_window_flag);
        @(negedge ref_clk);
        check(16'(ss_control_flag), 16'h0001);
        settle();
        check(16'(saw_disc), 16'h0001);
        $display("test capacitive timeout done");
        note(30 + 8 + DT_MIN_CYC, 30 + 8 + DT_MIN_CYC + 12);
        @(posedge dead_window_flag);
        repeat (30) @(negedge ref_clk);
        cap_fault = 1'b0;
        settle();
        @(posedge dead_window_flag);
        @(negedge ref_clk);
        check(16'(ss_control_flag), 16'h0000);
        $display("test capacitive recovery done");
        // Soft start restarted: first half period short, then boost decays away
        @(negedge high_gate_drive or negedge low_gate_drive);
        t0 = $realtime;
        @(negedge high_gate_drive or negedge low_gate_drive);
        early = int'(($realtime - t0) / 20.0);
        repeat (2200) @(negedge ref_clk);
        @(negedge high_gate_drive);
        t0 = $realtime;
        @(negedge low_gate_drive);
        t1 = $realtime;
        @(negedge high_gate_drive);
        check(16'(int'((t1 - t0) / 20.0)), 16'(int'(($realtime - t1) / 20.0)));
        check(16'(early < int'((t1 - t0) / 20.0)), 16'h0001);
        $display("test oscillator symmetry done");
        wrap_up();
    end
    initial begin
        #1000000;
        num_errors++;
        wrap_up();
    end
endmodule
bind halfbridge_deadtime_cap_guard hb_guard_props #(.CAP_TIMEOUT_CYC(CAP_TIMEOUT_CYC)) hb_guard_props_inst (
    .ref_clk(ref_clk), .reset(reset), .high_gate_drive(high_gate_drive),
    .low_gate_drive(low_gate_drive), .dead_window_flag(dead_window_flag),
    .ss_control_flag(ss_control_flag), .ss_discharge(ss_discharge), .timing_ramp(timing_ramp));
